// *** rtl/csoc_pkg.sv ***
package csoc_pkg;

   // ==========================================================
   // Widths
   localparam int ADC_W = 12;
   localparam int IDX_W = 10;
   localparam int CODE_W = 5;
   localparam int FS_W = 18;
   localparam int LSB_W = 14;
   localparam int ST_W = 2;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_PRI_VALUE = 10'h013;
   localparam logic [IDX_W-1:0] IDX_PRI_LIMIT = 10'h022;
   localparam logic [IDX_W-1:0] IDX_SEC_GAIN = 10'h023;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h030;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h031;
   localparam int ADDR_IDX_LSB = 2;

   // ==========================================================
   // Field layout of the secondary gain trim register
   localparam int RANGE_MSB = 7;
   localparam int RANGE_LSB = 6;
   localparam int POL_BIT = 5;
   localparam int MAG_MSB = 4;
   localparam int MAG_LSB = 0;

   // ==========================================================
   // Status bits
   localparam int ST_OCP = 0;
   localparam int ST_RSVD_RANGE = 1;
   localparam int ST_LIVE_OCP = 2;

   // ==========================================================
   // Reset values
   localparam logic [CODE_W-1:0] RST_LIMIT = 5'h1f;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [ST_W-1:0] RST_MASK = 2'h0;

   // ==========================================================
   // Primary threshold scaling: code / 31 * 1.38 of nominal reading
   localparam int LIMIT_MAX_CODE = 31;
   localparam int LIMIT_PCT = 138;
   localparam int PCT_DIV = 100;
   localparam int NOMINAL_CODE = 2048;

   // ==========================================================
   // Secondary full-scale range codes and their settings
   typedef enum logic [1:0] {
      RANGE_37MV = 2'b00,
      RANGE_75MV = 2'b01,
      RANGE_150MV = 2'b10,
      RANGE_RSVD = 2'b11
   } csoc_range_type;
   // Full scale in uV, LSB step in units of 10 nV
   localparam logic [FS_W-1:0] FS_37MV = 18'h0927c;
   localparam logic [FS_W-1:0] FS_75MV = 18'h124f8;
   localparam logic [FS_W-1:0] FS_150MV = 18'h249f0;
   localparam logic [LSB_W-1:0] LSB_37MV = 14'h05f6;
   localparam logic [LSB_W-1:0] LSB_75MV = 14'h0bec;
   localparam logic [LSB_W-1:0] LSB_150MV = 14'h17d8;
   localparam int GAIN_SHIFT = 8;

   // ==========================================================
   // AHB-Lite
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic polarity_neg;
      logic [CODE_W-1:0] magnitude;
   } csoc_gain_cfg_type;

   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [IDX_W-1:0] wr_idx;
      logic [CODE_W-1:0] limit_code;
      logic [7:0] gain_trim;
      logic [ADC_W-1:0] pri_value;
      logic ocp;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic irq;
      logic [FS_W-1:0] fs_uv;
      logic [LSB_W-1:0] lsb_step;
   } csoc_state_type;

   typedef struct packed {
      logic [ADC_W-1:0] calibrated;
   } csoc_gain_state_type;

endpackage

// *** rtl/csoc_gain_trim.sv ***
`timescale 1ns/100ps
module csoc_gain_trim (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [csoc_pkg::ADC_W-1:0] raw,
   input wire csoc_pkg::csoc_gain_cfg_type cfg,
   output logic [csoc_pkg::ADC_W-1:0] calibrated
);

   // ==========================================================
   // Gain correction
   localparam int PROD_W = csoc_pkg::ADC_W + csoc_pkg::CODE_W;
   csoc_pkg::csoc_gain_state_type s;
   csoc_pkg::csoc_gain_state_type next_s;
   logic [PROD_W-1:0] prod;
   logic [csoc_pkg::ADC_W:0] sum;
   logic [csoc_pkg::ADC_W-1:0] delta;

   always_comb begin
      next_s = s;
      prod = PROD_W'(raw) * PROD_W'(cfg.magnitude);
      delta = csoc_pkg::ADC_W'(prod >> csoc_pkg::GAIN_SHIFT);
      sum = {1'b0, raw} + {1'b0, delta};
      if (cfg.polarity_neg) begin
         next_s.calibrated = raw - delta;
      end else if (sum[csoc_pkg::ADC_W]) begin
         next_s.calibrated = '1;
      end else begin
         next_s.calibrated = sum[csoc_pkg::ADC_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign calibrated = s.calibrated;

   // ==========================================================
   // Checks
   property p_neg_gain;
      @(posedge clk) disable iff (!arst_n)
      cfg.polarity_neg |=> (calibrated <= $past(raw));
   endproperty
   a_neg_gain: assert property (p_neg_gain)
      else $error("negative gain raised the reading");

   property p_pos_gain;
      @(posedge clk) disable iff (!arst_n)
      (!cfg.polarity_neg && cfg.magnitude != '0 &&
         raw[csoc_pkg::ADC_W-1]) |=>
         (calibrated > $past(raw) || calibrated == '1);
   endproperty
   a_pos_gain: assert property (p_pos_gain)
      else $error("positive gain did not raise the reading");

   property p_zero_mag;
      @(posedge clk) disable iff (!arst_n)
      (cfg.magnitude == '0) |=> (calibrated == $past(raw));
   endproperty
   a_zero_mag: assert property (p_zero_mag)
      else $error("zero gain magnitude changed the reading");

   c_neg_gain: cover property (@(posedge clk) disable iff (!arst_n)
      cfg.polarity_neg && cfg.magnitude != '0 && raw != '0);

endmodule // csoc_gain_trim

// *** rtl/csoc_top.sv ***
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module csoc_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [csoc_pkg::ADC_W-1:0] primary_adc_value,
   input wire logic [csoc_pkg::ADC_W-1:0] secondary_adc_value,
   output logic primary_overcurrent,
   output logic [csoc_pkg::ADC_W-1:0] secondary_calibrated,
   output logic [csoc_pkg::FS_W-1:0] secondary_fullscale_uv,
   output logic [csoc_pkg::LSB_W-1:0] secondary_lsb_step,
   output logic irq
);

   // ==========================================================
   // Threshold table
   localparam int NUM_CODES = csoc_pkg::LIMIT_MAX_CODE + 1;
   localparam int LIM_W = csoc_pkg::ADC_W + 1;
   logic [LIM_W-1:0] limit_tbl [NUM_CODES];

   generate
      for (genvar c = 0; c < NUM_CODES; c++) begin : g_limit
         localparam int LIM = c * csoc_pkg::NOMINAL_CODE *
            csoc_pkg::LIMIT_PCT /
            (csoc_pkg::LIMIT_MAX_CODE * csoc_pkg::PCT_DIV);
         assign limit_tbl[c] = LIM_W'(LIM);
      end
   endgenerate

   // ==========================================================
   // State
   csoc_pkg::csoc_state_type s;
   csoc_pkg::csoc_state_type next_s;
   csoc_pkg::csoc_gain_cfg_type gain_cfg;
   logic addr_phase;
   logic rsvd_evt;
   logic ocp_rise;
   logic [csoc_pkg::IDX_W-1:0] rd_idx;

   assign addr_phase = hsel && hready && (htrans == csoc_pkg::HTRANS_NONSEQ);
   assign rd_idx = haddr[csoc_pkg::ADDR_IDX_LSB +: csoc_pkg::IDX_W];

   always_comb begin
      next_s = s;
      rsvd_evt = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hresp = csoc_pkg::HRESP_OKAY;
      // Write data phase
      if (s.wr_pend) begin
         unique case (s.wr_idx)
            csoc_pkg::IDX_PRI_LIMIT: begin
               next_s.limit_code = hwdata[csoc_pkg::CODE_W-1:0];
            end
            csoc_pkg::IDX_SEC_GAIN: begin
               next_s.gain_trim = hwdata[7:0];
               rsvd_evt = (hwdata[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB]
                  == csoc_pkg::RANGE_RSVD);
            end
            csoc_pkg::IDX_IRQ_STATUS: begin
               next_s.status = s.status & ~hwdata[csoc_pkg::ST_W-1:0];
            end
            csoc_pkg::IDX_IRQ_MASK: begin
               next_s.mask = hwdata[csoc_pkg::ST_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Address phase
      next_s.wr_pend = addr_phase && hwrite;
      next_s.wr_idx = addr_phase ? rd_idx : s.wr_idx;
      // Primary overcurrent compare
      next_s.pri_value = primary_adc_value;
      next_s.ocp = {1'b0, s.pri_value} > limit_tbl[s.limit_code];
      ocp_rise = next_s.ocp && !s.ocp;
      // Events set after the clear so a set wins
      if (ocp_rise) begin
         next_s.status[csoc_pkg::ST_OCP] = 1'b1;
      end
      if (rsvd_evt) begin
         next_s.status[csoc_pkg::ST_RSVD_RANGE] = 1'b1;
      end
      next_s.irq = |(next_s.status & next_s.mask);
      // Secondary range decode
      unique case (csoc_pkg::csoc_range_type'(
            next_s.gain_trim[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB]))
         csoc_pkg::RANGE_75MV: begin
            next_s.fs_uv = csoc_pkg::FS_75MV;
            next_s.lsb_step = csoc_pkg::LSB_75MV;
         end
         csoc_pkg::RANGE_150MV: begin
            next_s.fs_uv = csoc_pkg::FS_150MV;
            next_s.lsb_step = csoc_pkg::LSB_150MV;
         end
         csoc_pkg::RANGE_37MV, csoc_pkg::RANGE_RSVD: begin
            next_s.fs_uv = csoc_pkg::FS_37MV;
            next_s.lsb_step = csoc_pkg::LSB_37MV;
         end
      endcase
      // Read data, taken from the updated copy
      next_s.hrdata = '0;
      if (addr_phase && !hwrite) begin
         unique case (rd_idx)
            csoc_pkg::IDX_PRI_VALUE: begin
               next_s.hrdata = 32'(next_s.pri_value);
            end
            csoc_pkg::IDX_PRI_LIMIT: begin
               next_s.hrdata = 32'(next_s.limit_code);
            end
            csoc_pkg::IDX_SEC_GAIN: begin
               next_s.hrdata = 32'(next_s.gain_trim);
            end
            csoc_pkg::IDX_IRQ_STATUS: begin
               next_s.hrdata = 32'({next_s.ocp, next_s.status});
            end
            csoc_pkg::IDX_IRQ_MASK: begin
               next_s.hrdata = 32'(next_s.mask);
            end
            default: begin
               next_s.hrdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.hreadyout <= 1'b1;
         s.limit_code <= csoc_pkg::RST_LIMIT;
         s.gain_trim <= csoc_pkg::RST_GAIN;
         s.mask <= csoc_pkg::RST_MASK;
         s.fs_uv <= csoc_pkg::FS_37MV;
         s.lsb_step <= csoc_pkg::LSB_37MV;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Secondary gain path
   assign gain_cfg = {
      s.gain_trim[csoc_pkg::POL_BIT],
      s.gain_trim[csoc_pkg::MAG_MSB:csoc_pkg::MAG_LSB]
   };

   csoc_gain_trim u_gain (
      .clk(clk),
      .arst_n(arst_n),
      .raw(secondary_adc_value),
      .cfg(gain_cfg),
      .calibrated(secondary_calibrated)
   );

   // ==========================================================
   // Outputs
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign hrdata = s.hrdata;
   assign primary_overcurrent = s.ocp;
   assign secondary_fullscale_uv = s.fs_uv;
   assign secondary_lsb_step = s.lsb_step;
   assign irq = s.irq;

   // ==========================================================
   // Checks
   localparam int FULL_LIMIT = csoc_pkg::NOMINAL_CODE *
      csoc_pkg::LIMIT_PCT / csoc_pkg::PCT_DIV;

   property p_ocp_compare;
      @(posedge clk) disable iff (!arst_n)
      ##1 (primary_overcurrent ==
         ({1'b0, $past(s.pri_value)} > limit_tbl[$past(s.limit_code)]));
   endproperty
   a_ocp_compare: assert property (p_ocp_compare)
      else $error("overcurrent flag disagrees with compare");

   property p_value_follows;
      @(posedge clk) disable iff (!arst_n)
      (primary_adc_value > 12'h000 && s.limit_code == 5'h00 &&
         !(s.wr_pend && s.wr_idx == csoc_pkg::IDX_PRI_LIMIT)) |=>
         ##1 primary_overcurrent;
   endproperty
   a_value_follows: assert property (p_value_follows)
      else $error("reading above zero limit did not raise flag");

   property p_limit_ends;
      @(posedge clk) disable iff (!arst_n)
      (limit_tbl[0] == '0) &&
         (limit_tbl[csoc_pkg::LIMIT_MAX_CODE] == LIM_W'(FULL_LIMIT));
   endproperty
   a_limit_ends: assert property (p_limit_ends)
      else $error("threshold span is not 0 to 138 percent");

   property p_range_75;
      @(posedge clk) disable iff (!arst_n)
      (s.gain_trim[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB] == 2'b01) |->
         (secondary_lsb_step == csoc_pkg::LSB_75MV &&
          secondary_fullscale_uv == csoc_pkg::FS_75MV);
   endproperty
   a_range_75: assert property (p_range_75)
      else $error("75 mV range not applied");

   property p_range_150;
      @(posedge clk) disable iff (!arst_n)
      (s.gain_trim[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB] == 2'b10) |->
         (secondary_lsb_step == csoc_pkg::LSB_150MV &&
          secondary_fullscale_uv == csoc_pkg::FS_150MV);
   endproperty
   a_range_150: assert property (p_range_150)
      else $error("150 mV range not applied");

   property p_range_37;
      @(posedge clk) disable iff (!arst_n)
      (s.gain_trim[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB] ==
         csoc_pkg::RANGE_37MV) |->
         (secondary_lsb_step == csoc_pkg::LSB_37MV &&
          secondary_fullscale_uv == csoc_pkg::FS_37MV);
   endproperty
   a_range_37: assert property (p_range_37)
      else $error("37.5 mV range not applied");

   property p_range_rsvd;
      @(posedge clk) disable iff (!arst_n)
      (s.wr_pend && s.wr_idx == csoc_pkg::IDX_SEC_GAIN &&
         hwdata[csoc_pkg::RANGE_MSB:csoc_pkg::RANGE_LSB] ==
         csoc_pkg::RANGE_RSVD) |=>
         (s.status[csoc_pkg::ST_RSVD_RANGE] &&
          secondary_lsb_step == csoc_pkg::LSB_37MV &&
          secondary_fullscale_uv == csoc_pkg::FS_37MV);
   endproperty
   a_range_rsvd: assert property (p_range_rsvd)
      else $error("reserved range write not handled");

   property p_irq_level;
      @(posedge clk) disable iff (!arst_n)
      irq == |(s.status & s.mask);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt does not match masked status");

   property p_ocp_sticky;
      @(posedge clk) disable iff (!arst_n)
      $rose(primary_overcurrent) |-> s.status[csoc_pkg::ST_OCP];
   endproperty
   a_ocp_sticky: assert property (p_ocp_sticky)
      else $error("overcurrent event not recorded");

   property p_read_answer;
      @(posedge clk) disable iff (!arst_n)
      (addr_phase && !hwrite && rd_idx == csoc_pkg::IDX_SEC_GAIN &&
         !s.wr_pend) |=> (hrdata == 32'($past(s.gain_trim)) && hreadyout);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("gain trim read back wrong");

   property p_status_clear;
      @(posedge clk) disable iff (!arst_n)
      (s.wr_pend && s.wr_idx == csoc_pkg::IDX_IRQ_STATUS &&
         hwdata[csoc_pkg::ST_OCP] && !ocp_rise) |=>
         !s.status[csoc_pkg::ST_OCP];
   endproperty
   a_status_clear: assert property (p_status_clear)
      else $error("status write of one did not clear the event");

   property p_set_wins;
      @(posedge clk) disable iff (!arst_n)
      ocp_rise |=> s.status[csoc_pkg::ST_OCP];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("overcurrent event lost");

   property p_limit_write;
      @(posedge clk) disable iff (!arst_n)
      (s.wr_pend && s.wr_idx == csoc_pkg::IDX_PRI_LIMIT) |=>
         (s.limit_code == csoc_pkg::CODE_W'($past(hwdata)));
   endproperty
   a_limit_write: assert property (p_limit_write)
      else $error("limit code write did not land");

   property p_value_reg;
      @(posedge clk) disable iff (!arst_n)
      $past(arst_n) |-> (s.pri_value == $past(primary_adc_value));
   endproperty
   a_value_reg: assert property (p_value_reg)
      else $error("value register does not hold the reading");

   c_ocp_rise: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(primary_overcurrent));
   c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
   c_range_150: cover property (@(posedge clk) disable iff (!arst_n)
      secondary_lsb_step == csoc_pkg::LSB_150MV);
   c_rsvd: cover property (@(posedge clk) disable iff (!arst_n)
      s.status[csoc_pkg::ST_RSVD_RANGE]);

endmodule // csoc_top

// *** tb/csoc_top_test.sv ***
`timescale 1ns/100ps
module csoc_top_test;
   // ==========================================================
   // Signals
   localparam logic [9:0] R_VAL = csoc_pkg::IDX_PRI_VALUE;
   localparam logic [9:0] R_LIM = csoc_pkg::IDX_PRI_LIMIT;
   localparam logic [9:0] R_GAIN = csoc_pkg::IDX_SEC_GAIN;
   localparam logic [9:0] R_ST = csoc_pkg::IDX_IRQ_STATUS;
   localparam logic [9:0] R_MSK = csoc_pkg::IDX_IRQ_MASK;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, pri_oc;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [csoc_pkg::ADC_W-1:0] pri_adc, sec_adc, sec_cal;
   logic [csoc_pkg::FS_W-1:0] fs_uv;
   logic [csoc_pkg::LSB_W-1:0] lsb;
   logic [11:0] lim;
   int fail_count, tests_run, i;
   logic [17:0] fs_t [3] = '{18'h0927c, 18'h124f8, 18'h249f0};
   logic [13:0] lsb_t [3] = '{14'h05f6, 14'h0bec, 14'h17d8};
   logic [7:0] g_t [6] = '{8'h10, 8'h30, 8'h40, 8'h9f, 8'h3f, 8'h1f};
   logic [11:0] r_t [6] = '{12'h800, 12'h800, 12'h800, 12'h100, 12'h100,
      12'hf00};
   logic [11:0] c_t [6] = '{12'h880, 12'h780, 12'h800, 12'h11f, 12'h0e1,
      12'hfff};
   logic [4:0] code_t [3] = '{5'h00, 5'h0a, 5'h1f};

   csoc_top dut_u (
      .clk(clk),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .primary_adc_value(pri_adc),
      .secondary_adc_value(sec_adc),
      .primary_overcurrent(pri_oc),
      .secondary_calibrated(sec_cal),
      .secondary_fullscale_uv(fs_uv),
      .secondary_lsb_step(lsb),
      .irq(irq)
   );

   // ==========================================================
   // Tasks
   task automatic final_report;
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         $display("ERROR %0t: bus timeout", $time);
         final_report;
      end
   endtask

   task automatic bus(input logic w, input logic [9:0] idx,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, idx, 2'b00};
      htrans <= csoc_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      chk({31'h0, hresp}, {31'h0, csoc_pkg::HRESP_OKAY});
   endtask

   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask

   // ==========================================================
   // Clock and sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pri_adc = 12'h000;
      sec_adc = 12'h000;
      fail_count = 0;
      tests_run = 0;
      tick(10);
      arst_n <= 1'b1;
      tick(1);
      // Reset values
      chk(fs_uv, fs_t[0]);
      chk(lsb, lsb_t[0]);
      rdc(R_LIM, 32'h1f);
      rdc(R_GAIN, 32'h0);
      rdc(R_ST, 32'h0);
      rdc(R_MSK, 32'h0);
      // Range table and gain register readback
      for (i = 0; i < 3; i++) begin
         wr(R_GAIN, {24'h0, i[1:0], 6'h35});
         tick(1);
         chk(fs_uv, fs_t[i]);
         chk(lsb, lsb_t[i]);
         rdc(R_GAIN, {24'h0, i[1:0], 6'h35});
      end
      // Reserved range code
      wr(R_MSK, 32'h2);
      wr(R_GAIN, 32'hc0);
      tick(2);
      chk(fs_uv, fs_t[0]);
      chk(lsb, lsb_t[0]);
      chk(irq, 1'b1);
      rdc(R_ST, 32'h2);
      wr(R_ST, 32'h2);
      tick(2);
      chk(irq, 1'b0);
      rdc(R_ST, 32'h0);
      // Polarity and magnitude
      for (i = 0; i < 6; i++) begin
         sec_adc <= r_t[i];
         wr(R_GAIN, {24'h0, g_t[i]});
         tick(3);
         chk(sec_cal, c_t[i]);
      end
      // Overcurrent at several limit codes
      wr(R_MSK, 32'h1);
      for (i = 0; i < 3; i++) begin
         lim = 12'(int'(code_t[i]) * csoc_pkg::NOMINAL_CODE *
            csoc_pkg::LIMIT_PCT /
            (csoc_pkg::LIMIT_MAX_CODE * csoc_pkg::PCT_DIV));
         wr(R_LIM, {27'h0, code_t[i]});
         pri_adc <= lim;
         tick(4);
         chk(pri_oc, 1'b0);
         chk(irq, 1'b0);
         rdc(R_VAL, {20'h0, lim});
         pri_adc <= lim + 12'h001;
         tick(4);
         chk(pri_oc, 1'b1);
         chk(irq, 1'b1);
         rdc(R_ST, 32'h5);
         pri_adc <= 12'h000;
         tick(4);
         chk(pri_oc, 1'b0);
         rdc(R_ST, 32'h1);
         wr(R_ST, 32'h1);
         tick(2);
         chk(irq, 1'b0);
         rdc(R_ST, 32'h0);
      end
      // Masked event and register width
      wr(R_MSK, 32'h0);
      pri_adc <= 12'hfff;
      tick(4);
      chk(pri_oc, 1'b1);
      chk(irq, 1'b0);
      rdc(R_ST, 32'h5);
      pri_adc <= 12'h000;
      wr(R_ST, 32'h1);
      wr(R_LIM, 32'hffffffe5);
      rdc(R_LIM, 32'h05);
      // Unmapped place
      wr(10'h3ff, 32'hffffffff);
      rdc(10'h3ff, 32'h0);
      final_report;
   end
endmodule // csoc_top_test
